/* pkg/bfx_pkg.sv */
package bfx_pkg;
    // datapath widths
    localparam int unsigned DW   = 8;           // register width
    localparam int unsigned AW   = 16;          // memory address width
    localparam int unsigned NREG = 32;          // general registers

    // status flag bit positions
    localparam logic [2:0] FLAG_C = 3'h0;       // carry
    localparam logic [2:0] FLAG_Z = 3'h1;       // zero
    localparam logic [2:0] FLAG_N = 3'h2;       // negative
    localparam logic [2:0] FLAG_V = 3'h3;       // overflow
    localparam logic [2:0] FLAG_S = 3'h4;       // signed test
    localparam logic [2:0] FLAG_H = 3'h5;       // half carry
    localparam logic [2:0] FLAG_T = 3'h6;       // bit transfer
    localparam logic [2:0] FLAG_I = 3'h7;       // global interrupt

    // register indices of r0 and the pointer pairs (low byte)
    localparam logic [4:0] REG_R0 = 5'h00;      // implied target
    localparam logic [4:0] REG_XL = 5'h1A;      // pointer x
    localparam logic [4:0] REG_YL = 5'h1C;      // pointer y
    localparam logic [4:0] REG_ZL = 5'h1E;      // pointer z

    // pointer select
    localparam logic [1:0] PTR_X = 2'h0;
    localparam logic [1:0] PTR_Y = 2'h1;
    localparam logic [1:0] PTR_Z = 2'h2;

    // addressing modes
    localparam logic [1:0] MODE_PLAIN = 2'h0;   // pointer unchanged
    localparam logic [1:0] MODE_INC   = 2'h1;   // post increment
    localparam logic [1:0] MODE_DEC   = 2'h2;   // pre decrement
    localparam logic [1:0] MODE_IMPL  = 2'h3;   // implied r0 target

    // reset values and steps
    localparam logic [15:0] SP_RESET   = 16'h00FF;
    localparam logic [7:0]  FLAGS_RESET = 8'h00;
    localparam logic [15:0] PTR_STEP   = 16'h0001;

    // operations
    typedef enum logic [4:0] {
        OP_NOP, OP_ROT_RC, OP_ASHR, OP_NIB_SWAP, OP_FLAG_SET, OP_FLAG_CLR,
        OP_BIT_TO_T, OP_T_TO_BIT, OP_WORD_COPY, OP_LOAD_IND, OP_LOAD_DISP,
        OP_LOAD_DIR, OP_WRITE_IND, OP_WRITE_DISP, OP_WRITE_DIR, OP_PMEM_READ,
        OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP, OP_SLEEP, OP_WD_RESTART, OP_BREAK
    } bfx_op_t;

    // sequencer states
    typedef enum logic [1:0] {
        S_IDLE, S_DATA, S_PROG, S_PROG_WAIT
    } bfx_state_t;
endpackage

/* core/bfx_shift_unit.sv */
`timescale 1ns/10ps
module bfx_shift_unit (
    input  wire bfx_pkg::bfx_op_t i_op,    // operation
    input  wire logic [7:0]       i_val,   // operand
    input  wire logic             i_carry, // carry in
    output logic [7:0]            o_res,   // result
    output logic                  o_c,     // carry out
    output logic                  o_z,     // zero
    output logic                  o_n,     // negative
    output logic                  o_v      // overflow
);
    import bfx_pkg::*;

    // byte shifter and its flag terms
    always_comb begin
        o_res = i_val;
        o_c   = i_carry;
        unique case (i_op)
            OP_ROT_RC: begin
                o_res = {i_carry, i_val[7:1]};
                o_c   = i_val[0];
            end
            OP_ASHR: begin
                o_res = {i_val[7], i_val[7:1]};
                o_c   = i_val[0];
            end
            OP_NIB_SWAP: begin
                o_res = {i_val[3:0], i_val[7:4]};
            end
            default: begin // pass through
            end
        endcase
        o_z = (o_res == 8'h00);
        o_n = o_res[7];
        // overflow after a right shift is n xor c
        o_v = o_n ^ o_c;
    end
endmodule // bfx_shift_unit

/* core/bfx_exec.sv */
`timescale 1ns/10ps
module bfx_exec (
    input  wire logic                 I_REF_CLK,    // system clock
    input  wire logic                 I_RST_B,      // async reset, low
    input  wire logic                 I_START,      // start instruction
    input  wire bfx_pkg::bfx_op_t     I_OP,         // operation
    input  wire logic [4:0]           I_RD,         // destination reg
    input  wire logic [4:0]           I_RR,         // source reg
    input  wire logic [2:0]           I_BIT,        // bit or flag index
    input  wire logic [1:0]           I_PTR,        // pointer select
    input  wire logic [1:0]           I_MODE,       // addressing mode
    input  wire logic [5:0]           I_DISP,       // displacement q
    input  wire logic [15:0]          I_K,          // absolute address
    input  wire logic [5:0]           I_PORT,       // io address
    output logic                      O_BUSY,       // multi cycle op
    output logic                      O_DONE,       // op complete pulse
    output logic [15:0]               O_DM_ADDR,    // data mem address
    output logic [7:0]                O_DM_WDATA,   // data mem write data
    output logic                      O_DM_WR,      // data mem write
    output logic                      O_DM_RD,      // data mem read
    input  wire logic [7:0]           I_DM_RDATA,   // data mem read data
    output logic [15:0]               O_PM_ADDR,    // program byte addr
    output logic                      O_PM_RD,      // program read
    input  wire logic [7:0]           I_PM_RDATA,   // program read data
    output logic [5:0]                O_IO_ADDR,    // io address
    output logic [7:0]                O_IO_WDATA,   // io write data
    output logic                      O_IO_WR,      // io write
    output logic                      O_IO_RD,      // io read side effect
    input  wire logic [7:0]           I_IO_RDATA,   // io data at I_PORT
    output logic                      O_SLEEP,      // sleep request
    output logic                      O_WD_RESTART, // watchdog restart
    output logic                      O_BREAK,      // debug break
    output logic [7:0]                O_FLAGS,      // status_flags
    output logic [15:0]               O_SP,         // stack pointer
    input  wire logic                 I_RF_WE,      // debug reg write
    input  wire logic [4:0]           I_RF_ADDR,    // debug reg address
    input  wire logic [7:0]           I_RF_WDATA,   // debug write data
    output logic [7:0]                O_RF_RDATA    // debug read data
);
    import bfx_pkg::*;

    logic [DW-1:0]  rf [0:NREG-1];   // general registers
    bfx_state_t     state_reg;       // sequencer state
    bfx_state_t     state_next;      // next state
    logic [7:0]     flags_reg;       // status_flags
    logic [15:0]    sp_reg;          // stack pointer
    logic [4:0]     dst_reg;         // pending load target
    logic           busy_reg;        // multi cycle in flight
    logic           take;            // instruction accepted
    logic [4:0]     ptr_lo;          // selected pointer low
    logic [4:0]     ptr_hi;          // selected pointer high
    logic [15:0]    ptr_val;         // selected pointer value
    logic [15:0]    ptr_inc;         // pointer plus one
    logic [15:0]    ptr_dec;         // pointer minus one
    logic [15:0]    z_val;           // pointer z value
    logic [15:0]    dm_addr;         // data address of op
    logic [7:0]     src_val;         // source register
    logic [7:0]     sh_res;          // shifter result
    logic           sh_c;            // shifter carry
    logic           sh_z;            // shifter zero
    logic           sh_n;            // shifter negative
    logic           sh_v;            // shifter overflow

    // low register index of a pointer pair
    function automatic logic [4:0] ptr_index(input logic [1:0] sel);
        return (sel == PTR_Y) ? REG_YL : (sel == PTR_Z) ? REG_ZL : REG_XL;
    endfunction

    // ops that keep the sequencer past the take edge
    function automatic logic is_multi(input bfx_op_t op);
        return op inside {OP_LOAD_IND, OP_LOAD_DISP, OP_LOAD_DIR, OP_WRITE_IND, OP_WRITE_DISP, OP_WRITE_DIR,
                          OP_PUSH, OP_POP, OP_PMEM_READ};
    endfunction

    // only an idle sequencer accepts a start
    assign take = I_START && (state_reg == S_IDLE);

    // operand fetch and address arithmetic
    always_comb begin
        ptr_lo  = ptr_index(I_PTR);
        ptr_hi  = {ptr_lo[4:1], 1'b1};
        ptr_val = {rf[ptr_hi], rf[ptr_lo]};
        ptr_inc = ptr_val + PTR_STEP;
        ptr_dec = ptr_val - PTR_STEP;
        z_val   = {rf[REG_ZL + 5'h01], rf[REG_ZL]};
        src_val = rf[I_RR];
        unique case (I_OP)
            OP_LOAD_IND, OP_WRITE_IND: begin
                // pre decrement uses the new value
                dm_addr = (I_MODE == MODE_DEC) ? ptr_dec : ptr_val;
            end
            OP_LOAD_DISP, OP_WRITE_DISP: begin
                dm_addr = ptr_val + {10'h000, I_DISP};
            end
            OP_LOAD_DIR, OP_WRITE_DIR: begin
                dm_addr = I_K;
            end
            OP_POP: begin
                // stack grows downward, pop pre increments
                dm_addr = sp_reg + PTR_STEP;
            end
            default: begin
                dm_addr = sp_reg; // push stores at sp
            end
        endcase
    end

    // shifter for rotate, shift and swap
    bfx_shift_unit u_shift (
        .i_op    (I_OP),
        .i_val   (rf[I_RD]),
        .i_carry (flags_reg[FLAG_C]),
        .o_res   (sh_res),
        .o_c     (sh_c),
        .o_z     (sh_z),
        .o_n     (sh_n),
        .o_v     (sh_v)
    );

    // sequencer next state
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: begin
                if (take && is_multi(I_OP)) begin
                    // program memory answers one cycle late
                    state_next = (I_OP == OP_PMEM_READ) ? S_PROG : S_DATA;
                end
            end
            S_PROG: begin
                state_next = S_PROG_WAIT;
            end
            S_DATA, S_PROG_WAIT: begin
                state_next = S_IDLE;
            end
        endcase
    end

    // sequencer state and busy flag
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            state_reg <= S_IDLE;
            busy_reg  <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg  <= (state_next != S_IDLE);
        end
    end

    // load target, held for the data return cycle
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            dst_reg <= REG_R0;
        end else if (take) begin
            // implied form of program read targets r0
            dst_reg <= ((I_OP == OP_PMEM_READ) && (I_MODE == MODE_IMPL)) ? REG_R0 : I_RD;
        end
    end

    // status flags; memory ops never touch them
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            flags_reg <= FLAGS_RESET;
        end else if (take) begin
            unique case (I_OP)
                OP_ROT_RC, OP_ASHR: begin
                    flags_reg[FLAG_C] <= sh_c;
                    flags_reg[FLAG_Z] <= sh_z;
                    flags_reg[FLAG_N] <= sh_n;
                    flags_reg[FLAG_V] <= sh_v;
                end
                OP_FLAG_SET: begin
                    // one flag, chosen by bit index
                    flags_reg[I_BIT] <= 1'b1;
                end
                OP_FLAG_CLR: begin
                    flags_reg[I_BIT] <= 1'b0;
                end
                OP_BIT_TO_T: begin
                    flags_reg[FLAG_T] <= src_val[I_BIT];
                end
                default: begin // no flag effect
                end
            endcase
        end
    end

    // stack pointer
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            sp_reg <= SP_RESET;
        end else if (take && (I_OP == OP_PUSH)) begin
            sp_reg <= sp_reg - PTR_STEP;
        end else if (take && (I_OP == OP_POP)) begin
            sp_reg <= sp_reg + PTR_STEP;
        end
    end

    // register file writes; data, not control, so no reset
    always_ff @(posedge I_REF_CLK) begin
        if (take) begin
            unique case (I_OP)
                OP_ROT_RC, OP_ASHR, OP_NIB_SWAP: begin
                    rf[I_RD] <= sh_res;
                end
                OP_T_TO_BIT: begin
                    rf[I_RD][I_BIT] <= flags_reg[FLAG_T];
                end
                OP_WORD_COPY: begin
                    // pairs are even aligned, low bit ignored
                    rf[{I_RD[4:1], 1'b0}] <= rf[{I_RR[4:1], 1'b0}];
                    rf[{I_RD[4:1], 1'b1}] <= rf[{I_RR[4:1], 1'b1}];
                end
                OP_IO_IN: begin
                    rf[I_RD] <= I_IO_RDATA;
                end
                OP_LOAD_IND, OP_WRITE_IND: begin
                    if (I_MODE == MODE_INC) begin
                        {rf[ptr_hi], rf[ptr_lo]} <= ptr_inc;
                    end else if (I_MODE == MODE_DEC) begin
                        {rf[ptr_hi], rf[ptr_lo]} <= ptr_dec;
                    end
                end
                OP_PMEM_READ: begin
                    if (I_MODE == MODE_INC) begin
                        {rf[REG_ZL + 5'h01], rf[REG_ZL]} <= z_val + PTR_STEP;
                    end
                end
                default: begin
                end
            endcase
        end else if ((state_reg == S_DATA) && O_DM_RD) begin
            // loaded byte wins over a pointer step
            rf[dst_reg] <= I_DM_RDATA;
        end else if (state_reg == S_PROG_WAIT) begin
            rf[dst_reg] <= I_PM_RDATA;
        end else if (I_RF_WE && (state_reg == S_IDLE)) begin
            // debug write only while idle
            rf[I_RF_ADDR] <= I_RF_WDATA;
        end
    end

    // data memory strobes, one cycle each
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_DM_ADDR  <= 16'h0000;
            O_DM_WDATA <= 8'h00;
            O_DM_WR    <= 1'b0;
            O_DM_RD    <= 1'b0;
        end else begin
            O_DM_WR <= 1'b0;
            O_DM_RD <= 1'b0;
            if (take) begin
                unique case (I_OP)
                    OP_LOAD_IND, OP_LOAD_DISP, OP_LOAD_DIR, OP_POP: begin
                        O_DM_ADDR <= dm_addr;
                        O_DM_RD   <= 1'b1;
                    end
                    OP_WRITE_IND, OP_WRITE_DISP, OP_WRITE_DIR, OP_PUSH: begin
                        O_DM_ADDR  <= dm_addr;
                        O_DM_WDATA <= src_val;
                        O_DM_WR    <= 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end

    // program memory read strobe
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_PM_ADDR <= 16'h0000;
            O_PM_RD   <= 1'b0;
        end else begin
            O_PM_RD <= take && (I_OP == OP_PMEM_READ);
            if (take && (I_OP == OP_PMEM_READ)) begin
                O_PM_ADDR <= z_val; // old z, increment is post
            end
        end
    end

    // io strobes; input data taken at start
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_IO_ADDR  <= 6'h00;
            O_IO_WDATA <= 8'h00;
            O_IO_WR    <= 1'b0;
            O_IO_RD    <= 1'b0;
        end else begin
            O_IO_WR <= take && (I_OP == OP_IO_OUT);
            O_IO_RD <= take && (I_OP == OP_IO_IN);
            if (take && (I_OP inside {OP_IO_OUT, OP_IO_IN})) begin
                O_IO_ADDR <= I_PORT;
                if (I_OP == OP_IO_OUT) begin
                    O_IO_WDATA <= src_val;
                end
            end
        end
    end

    // control pulses; their targets define the behaviour
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_SLEEP      <= 1'b0;
            O_WD_RESTART <= 1'b0;
            O_BREAK      <= 1'b0;
        end else begin
            O_SLEEP      <= take && (I_OP == OP_SLEEP);
            O_WD_RESTART <= take && (I_OP == OP_WD_RESTART);
            O_BREAK      <= take && (I_OP == OP_BREAK);
        end
    end

    // completion pulse marks the op boundary
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_DONE <= 1'b0;
        end else begin
            O_DONE <= (take && !is_multi(I_OP)) ||
                      (state_reg == S_DATA) ||
                      (state_reg == S_PROG_WAIT);
        end
    end

    // debug read port, registered
    always_ff @(posedge I_REF_CLK or negedge I_RST_B) begin
        if (!I_RST_B) begin
            O_RF_RDATA <= 8'h00;
        end else begin
            O_RF_RDATA <= rf[I_RF_ADDR];
        end
    end

    // outputs straight from their flops
    assign O_BUSY  = busy_reg;
    assign O_FLAGS = flags_reg;
    assign O_SP    = sp_reg;
endmodule // bfx_exec

/* tb/bfx_exec_props.sv */
`timescale 1ns/10ps
module bfx_exec_props
    import bfx_pkg::*;
(
    input  wire logic        I_REF_CLK, // system clock
    input  wire logic        I_RST_B,   // async reset, low
    input  wire logic        I_START,   // start pulse
    input  wire bfx_op_t     I_OP,      // operation
    input  wire logic [2:0]  I_BIT,     // flag index
    input  wire logic        O_BUSY,    // op in flight
    input  wire logic        O_DONE,    // completion pulse
    input  wire logic        O_DM_RD,   // data read strobe
    input  wire logic        O_DM_WR,   // data write strobe
    input  wire logic [15:0] O_DM_ADDR, // data address
    input  wire logic        O_PM_RD,   // program read strobe
    input  wire logic        O_SLEEP,   // sleep request
    input  wire logic [7:0]  O_FLAGS,   // status_flags
    input  wire logic [15:0] O_SP       // stack pointer
);
    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RST_B);
    wire go = I_START && !O_BUSY; // taken this edge

    property p_one_cyc;
        go && (I_OP inside {[OP_NOP:OP_WORD_COPY], [OP_IO_IN:OP_IO_OUT], [OP_SLEEP:OP_WD_RESTART]}) |=> O_DONE && !O_BUSY;
    endproperty
    a_one_cyc: assert property (p_one_cyc) else $error("one cycle op late");
    property p_dm_rd;
        O_DM_RD |-> O_BUSY ##1 (!O_DM_RD && !O_BUSY && O_DONE);
    endproperty
    a_dm_rd: assert property (p_dm_rd) else $error("read not 2 cycles");
    property p_dm_wr;
        O_DM_WR |-> O_BUSY ##1 (!O_DM_WR && !O_BUSY && O_DONE);
    endproperty
    a_dm_wr: assert property (p_dm_wr) else $error("write not 2 cycles");
    property p_pm;
        O_PM_RD |-> O_BUSY ##1 (O_BUSY && !O_PM_RD && !O_DONE) ##1 (O_DONE && !O_BUSY);
    endproperty
    a_pm: assert property (p_pm) else $error("prog read not 3 cycles");
    property p_fset;
        go && I_OP == OP_FLAG_SET |=> O_FLAGS == ($past(O_FLAGS) | (8'h01 << $past(I_BIT)));
    endproperty
    a_fset: assert property (p_fset) else $error("flag set wrong");
    property p_fclr;
        go && I_OP == OP_FLAG_CLR |=> O_FLAGS == ($past(O_FLAGS) & ~(8'h01 << $past(I_BIT)));
    endproperty
    a_fclr: assert property (p_fclr) else $error("flag clear wrong");
    property p_sleep;
        go && I_OP == OP_SLEEP |=> O_SLEEP && $stable(O_FLAGS);
    endproperty
    a_sleep: assert property (p_sleep) else $error("no sleep");
    property p_push;
        go && I_OP == OP_PUSH |=> O_DM_WR && O_DM_ADDR == $past(O_SP) && O_SP == $past(O_SP) - 16'h0001;
    endproperty
    a_push: assert property (p_push) else $error("push wrong");
endmodule // bfx_exec_props

bind bfx_exec bfx_exec_props u_props (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_START(I_START), .I_OP(I_OP),
    .I_BIT(I_BIT), .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_DM_RD(O_DM_RD), .O_DM_WR(O_DM_WR), .O_DM_ADDR(O_DM_ADDR),
    .O_PM_RD(O_PM_RD), .O_SLEEP(O_SLEEP), .O_FLAGS(O_FLAGS), .O_SP(O_SP));

/* tb/bfx_mem_model.sv */
`timescale 1ns/10ps
module bfx_mem_model (
    input  wire logic        i_clk,      // system clock
    input  wire logic [15:0] i_dm_addr,  // data address
    input  wire logic [7:0]  i_dm_wdata, // data write value
    input  wire logic        i_dm_wr,    // data write strobe
    input  wire logic        i_dm_rd,    // data read strobe
    output logic      [7:0]  o_dm_rdata, // data read value
    input  wire logic [15:0] i_pm_addr,  // program byte address
    input  wire logic        i_pm_rd,    // program read strobe
    output logic      [7:0]  o_pm_rdata, // program byte, next cycle
    input  wire logic [5:0]  i_port,     // io address at start
    input  wire logic [5:0]  i_io_addr,  // io write address
    input  wire logic [7:0]  i_io_wdata, // io write value
    input  wire logic        i_io_wr,    // io write strobe
    output logic      [7:0]  o_io_rdata  // io value at i_port
);
    logic [7:0] dm [0:65535]; // data space
    logic [7:0] io [0:63];    // io space
    logic [7:0] pm_q;         // program byte latched
    logic       pm_v = 1'b0;  // program byte valid
    // address patterns the bench can predict
    initial begin
        for (int i = 0; i < 65536; i++) dm[i] = 8'(i) ^ 8'(i >> 8) ^ 8'h3C;
        for (int i = 0; i < 64; i++) io[i] = {6'(i), 2'b01};
    end
    // released read lines show inverted data
    assign o_dm_rdata = i_dm_rd ? dm[i_dm_addr] : ~dm[i_dm_addr];
    assign o_pm_rdata = pm_v ? pm_q : ~pm_q;
    assign o_io_rdata = io[i_port];
    // writes on strobe edge; program byte a cycle late
    always @(posedge i_clk) begin
        if (i_dm_wr) dm[i_dm_addr] <= i_dm_wdata;
        if (i_io_wr) io[i_io_addr] <= i_io_wdata;
        pm_v <= i_pm_rd;
        if (i_pm_rd) pm_q <= i_pm_addr[7:0] ^ i_pm_addr[15:8] ^ 8'hC3;
    end
endmodule // bfx_mem_model

/* tb/tb.sv */
`timescale 1ns/10ps
module tb;
    import bfx_pkg::*;
    logic        I_REF_CLK = 0, I_RST_B = 0, I_START = 0, I_RF_WE = 0, rv_req = 0, rv_d = 0;
    bfx_op_t     I_OP = OP_NOP;
    logic [4:0]  I_RD = 0, I_RR = 0, I_RF_ADDR = 0;
    logic [2:0]  I_BIT = 0;
    logic [1:0]  I_PTR = 0, I_MODE = 0;
    logic [5:0]  I_DISP = 0, I_PORT = 0, O_IO_ADDR;
    logic [15:0] I_K = 0, O_DM_ADDR, O_PM_ADDR, O_SP;
    logic [7:0]  I_RF_WDATA = 0, dm_rd, pm_rd, io_rd, O_DM_WDATA, O_IO_WDATA, O_FLAGS, O_RF_RDATA;
    logic        O_BUSY, O_DONE, O_DM_WR, O_DM_RD, O_PM_RD, O_IO_WR;
    logic [7:0]  fl = 0, rv [0:31]; // expected flags and registers
    logic [23:0] wq [$], fq [$], rq [$]; // expected writes, flags, reads
    int          fail_count = 0, checks = 0, cyc = 0;

    bfx_exec dut (.I_REF_CLK(I_REF_CLK), .I_RST_B(I_RST_B), .I_START(I_START), .I_OP(I_OP), .I_RD(I_RD),
        .I_RR(I_RR), .I_BIT(I_BIT), .I_PTR(I_PTR), .I_MODE(I_MODE), .I_DISP(I_DISP), .I_K(I_K), .I_PORT(I_PORT),
        .O_BUSY(O_BUSY), .O_DONE(O_DONE), .O_DM_ADDR(O_DM_ADDR), .O_DM_WDATA(O_DM_WDATA), .O_DM_WR(O_DM_WR),
        .O_DM_RD(O_DM_RD), .I_DM_RDATA(dm_rd), .O_PM_ADDR(O_PM_ADDR), .O_PM_RD(O_PM_RD), .I_PM_RDATA(pm_rd),
        .O_IO_ADDR(O_IO_ADDR), .O_IO_WDATA(O_IO_WDATA), .O_IO_WR(O_IO_WR), .O_IO_RD(), .I_IO_RDATA(io_rd),
        .O_SLEEP(), .O_WD_RESTART(), .O_BREAK(), .O_FLAGS(O_FLAGS), .O_SP(O_SP), .I_RF_WE(I_RF_WE),
        .I_RF_ADDR(I_RF_ADDR), .I_RF_WDATA(I_RF_WDATA), .O_RF_RDATA(O_RF_RDATA));
    bfx_mem_model mem (.i_clk(I_REF_CLK), .i_dm_addr(O_DM_ADDR), .i_dm_wdata(O_DM_WDATA), .i_dm_wr(O_DM_WR),
        .i_dm_rd(O_DM_RD), .o_dm_rdata(dm_rd), .i_pm_addr(O_PM_ADDR), .i_pm_rd(O_PM_RD), .o_pm_rdata(pm_rd),
        .i_port(I_PORT), .i_io_addr(O_IO_ADDR), .i_io_wdata(O_IO_WDATA), .i_io_wr(O_IO_WR), .o_io_rdata(io_rd));

    initial forever #12.5 I_REF_CLK = ~I_REF_CLK;

    task automatic cmp(logic [23:0] e, logic [23:0] g);
        checks++;
        if (g !== e) begin
            fail_count++;
            $display("[FAIL] t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask
    task automatic test_done;
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // debug port write, shadow kept in step
    task automatic rfw(int a, logic [7:0] d);
        @(posedge I_REF_CLK);
        I_RF_WE <= 1'b1;
        I_RF_ADDR <= 5'(a);
        I_RF_WDATA <= d;
        rv[a] = d;
        @(posedge I_REF_CLK);
        I_RF_WE <= 1'b0;
    endtask
    // debug read, compared a cycle later
    task automatic rfr(int a);
        @(posedge I_REF_CLK);
        I_RF_ADDR <= 5'(a);
        rv_req <= 1'b1;
        rq.push_back(24'(rv[a]));
        @(posedge I_REF_CLK);
        rv_req <= 1'b0;
    endtask
    // one instruction; k feeds address, q and port
    task automatic ex(bfx_op_t op, int rd, int rr, int b = 0, int p = 0, int m = 0, int k = 0);
        int n = 0;
        fq.push_back(24'(fl));
        @(posedge I_REF_CLK);
        I_START <= 1'b1;
        I_OP <= op;
        I_RD <= 5'(rd);
        I_RR <= 5'(rr);
        I_BIT <= 3'(b);
        I_PTR <= 2'(p);
        I_MODE <= 2'(m);
        I_K <= 16'(k);
        I_DISP <= 6'(k);
        I_PORT <= 6'(k);
        @(posedge I_REF_CLK);
        I_START <= 1'b0;
        #1;
        while (O_DONE !== 1'b1 && n < 8) begin
            @(posedge I_REF_CLK);
            #1;
            n++;
        end
        if (n == 8) fail_count++;
    endtask
    // shift or rotate with flag prediction
    task automatic shr(bfx_op_t op, int r);
        logic [7:0] v;
        v = rv[r];
        rv[r] = (op == OP_ASHR) ? {v[7], v[7:1]} : {fl[FLAG_C], v[7:1]};
        fl[FLAG_C] = v[0];
        fl[FLAG_Z] = (rv[r] == 8'h00);
        fl[FLAG_N] = rv[r][7];
        fl[FLAG_V] = rv[r][7] ^ v[0];
        ex(op, r, r);
        rfr(r);
    endtask
    function automatic logic [7:0] dmv(logic [15:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction

    // watcher: reads, flags at done, writes
    always @(posedge I_REF_CLK) begin
        cyc++;
        if (cyc == 5000) begin
            fail_count++;
            test_done();
        end
        rv_d <= rv_req;
        if (rv_d) cmp(rq.pop_front(), 24'(O_RF_RDATA));
        if (O_DONE === 1'b1) cmp(fq.pop_front(), 24'(O_FLAGS));
        if (O_DM_WR === 1'b1) cmp(wq.pop_front(), {O_DM_ADDR, O_DM_WDATA});
    end

    initial begin
        void'($urandom(32'ha1a7d9fe));
        repeat (16) @(posedge I_REF_CLK);
        I_RST_B <= 1'b1;
        for (int i = 16; i < 19; i++) rfw(i, 8'($urandom));
        rfw(19, ~rv[18]);
        rfw(26, 8'h20); rfw(27, 8'h01); rfw(28, 8'h00); rfw(29, 8'h02); rfw(30, 8'h00); rfw(31, 8'h03);
        for (int i = 0; i < 16; i++) begin
            fl[i % 8] = (i < 8);
            ex(i < 8 ? OP_FLAG_SET : OP_FLAG_CLR, 0, 0, i % 8);
        end
        $display("flag ops done");
        fl[FLAG_C] = 1'b1;
        ex(OP_FLAG_SET, 0, 0, FLAG_C);
        shr(OP_ROT_RC, 16);
        shr(OP_ASHR, 17);
        fl[FLAG_T] = rv[18][3];
        ex(OP_BIT_TO_T, 0, 18, 3);
        rv[19][3] = fl[FLAG_T];
        ex(OP_T_TO_BIT, 19, 0, 3);
        rfr(19);
        rv[16] = {rv[16][3:0], rv[16][7:4]};
        ex(OP_NIB_SWAP, 16, 16);
        rfr(16);
        rv[2] = rv[18];
        rv[3] = rv[19];
        ex(OP_WORD_COPY, 3, 19);
        rfr(2); rfr(3);
        $display("register ops done");
        rv[20] = dmv(16'h0120); rv[26] = 8'h21;
        ex(OP_LOAD_IND, 20, 0, 0, PTR_X, MODE_INC);
        rfr(20); rfr(26);
        rv[21] = dmv(16'h01FF); rv[28] = 8'hFF; rv[29] = 8'h01;
        ex(OP_LOAD_IND, 21, 0, 0, PTR_Y, MODE_DEC);
        rfr(21); rfr(28); rfr(29);
        rv[22] = dmv(16'h033F);
        ex(OP_LOAD_DISP, 22, 0, 0, PTR_Z, MODE_PLAIN, 63);
        rfr(22); rfr(30);
        rv[23] = dmv(16'h0440);
        ex(OP_LOAD_DIR, 23, 0, 0, 0, 0, 16'h0440);
        rfr(23);
        wq.push_back({16'h0121, rv[18]}); rv[26] = 8'h22;
        ex(OP_WRITE_IND, 0, 18, 0, PTR_X, MODE_INC);
        rfr(26);
        wq.push_back({16'h01FE, rv[17]}); rv[28] = 8'hFE;
        ex(OP_WRITE_IND, 0, 17, 0, PTR_Y, MODE_DEC);
        rfr(28);
        wq.push_back({16'h0307, rv[16]});
        ex(OP_WRITE_DISP, 0, 16, 0, PTR_Z, MODE_PLAIN, 7);
        rfr(30);
        wq.push_back({16'h0450, rv[19]});
        ex(OP_WRITE_DIR, 0, 19, 0, 0, 0, 16'h0450);
        $display("memory ops done");
        rv[0] = 8'hC0;
        ex(OP_PMEM_READ, 5, 0, 0, PTR_Z, MODE_IMPL);
        rfr(0);
        rv[24] = 8'hC0; rv[30] = 8'h01;
        ex(OP_PMEM_READ, 24, 0, 0, PTR_Z, MODE_INC);
        rfr(24); rfr(30);
        wq.push_back({16'h00FF, rv[18]});
        ex(OP_PUSH, 0, 18);
        rv[25] = rv[18];
        ex(OP_POP, 25, 0);
        rfr(25);
        ex(OP_IO_OUT, 0, 16, 0, 0, 0, 5);
        rv[27] = rv[16];
        ex(OP_IO_IN, 27, 0, 0, 0, 0, 5);
        rfr(27);
        ex(OP_SLEEP, 0, 0);
        ex(OP_WD_RESTART, 0, 0);
        ex(OP_NOP, 0, 0);
        $display("stack, io, control ops done");
        repeat (4) @(posedge I_REF_CLK);
        test_done();
    end
endmodule // tb
